//--- adc_ctrl_consts.vh
// constants for the serial-controlled converter sequencer and its result fifo
// assumes a 100 MHz system clock; serial pins arrive from outside that domain
//
// Overview of operation
// R1 - host is serial master, clock at most 10MHz, mode 0 or mode 3.
// R2 - data input sampled on each rising serial clock edge while select low.
// R3 - data output changes on each falling serial clock edge.
// R4 - bipolar differential and temperature results two's complement, others straight binary.
// R5 - each transaction starts with command byte msb first; pairing write needs second byte.
// R6 - falling chip select starts byte reception; bytes shift in on rising edges.
// R7 - clock mode comes from bits 5 and 4 of the setup byte.
// R8 - mode 00: low start pulse launches whole internally timed sequence.
// R9 - mode 01: each start pulse converts one channel.
// R10 - mode 10 default after reset; conversion byte starts internal conversions.
// R11 - mode 11: serial clock times conversion; scanning and averaging disabled.
// R12 - modes 00 and 10: end flag low after last requested operation.
// R13 - mode 01: end flag low after each conversion.
// R14 - end flag high on select or start falling; always high in mode 11.
// R15 - differential pairs are even positive, odd negative channel.
// R16 - setup bits 1 and 0 select pairing register; a 1 makes pair differential.
// R17 - unipolar differential negative gives zero; single-ended always unipolar binary.
// R18 - fifo holds 16 results plus temperature slot; oldest overwritten when full.
// R19 - result read as two bytes: four leading zeros, two trailing sub-bits.
// R20 - after select falls, oldest unread byte shown msb first; empty reads zeros.
// R21 - temperature result read first after measurement; newer replaces unread one.
// R22 - internal oscillator 4.4MHz nominal, only in modes 00, 01 and 10.
// R23 - data output high impedance while select high.
// R24 - command target decoded from leading bits; bit 7 set means conversion.
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// -----------------------------------------------------------------------------
// command decode
// -----------------------------------------------------------------------------
`define CMD_CONV_BIT     7
`define CMD_SETUP_BIT    6
`define CMD_AVG_BIT      5
`define CMD_RESET_BIT    4
`define SETUP_CK_HI      5
`define SETUP_CK_LO      4
`define SETUP_DIFF_HI    1
`define SETUP_DIFF_LO    0
`define CLOCK_MODE_RESET 2'h2

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define SYS_CLK_MHZ      100
`define OSC_KHZ          4400
`define CONV_OSC_CYCLES  16
`define FIFO_DEPTH       16

`endif

//--- sample_unit.v
// one conversion worth of timing and result coding
// assumes an outside model drives the raw sample value and the temperature code
`default_nettype none
`include "adc_ctrl_consts.vh"

module sample_unit #(
	parameter OSC_DIV = `SYS_CLK_MHZ * 1000 / `OSC_KHZ
)(
	// clock and reset
	input  wire        clock_in,
	input  wire        rst_in,
	input  wire        enable_in,
	// control
	input  wire        start_in,
	input  wire        ext_tick_in,
	input  wire        use_ext_in,
	input  wire        temp_in,
	input  wire        diff_in,
	input  wire        bipolar_in,
	input  wire [10:0] raw_in,
	input  wire [11:0] temp_code_in,
	// result
	output reg         done_out,
	output reg  [15:0] word_out
);

	reg [4:0] div_q;
	reg [4:0] bits_q;
	reg       busy_q;
	wire      tick = use_ext_in ? ext_tick_in : (div_q == 5'h00);

	// -------------------------------------------------------------------------
	// conversion timing
	// -------------------------------------------------------------------------
	// raw_in is a signed difference; only the low ten bits form a bipolar code
	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_q    <= 5'h00;
			bits_q   <= 5'h00;
			busy_q   <= 1'b0;
			done_out <= 1'b0;
			word_out <= 16'h0000;
		end
		else if (enable_in)
		begin
			done_out <= 1'b0;
			// oscillator only stepped while an internally timed conversion runs [R22]
			if (busy_q && !use_ext_in)
				div_q <= (div_q == 5'h00) ? OSC_DIV[4:0] - 5'h01 : div_q - 5'h01;
			if (start_in && !busy_q)
			begin
				busy_q <= 1'b1;
				bits_q <= 5'h00;
			end
			else if (busy_q && tick)
			begin
				bits_q <= bits_q + 5'h01;
				if (bits_q == `CONV_OSC_CYCLES - 1)
				begin
					busy_q   <= 1'b0;
					done_out <= 1'b1;
					if (temp_in)
						word_out <= {4'h0, temp_code_in}; // [R4] [R21]
					else if (diff_in && bipolar_in)
						word_out <= {4'h0, raw_in[9:0], 2'h0}; // [R4] [R15]
					else if (raw_in[10])
						word_out <= 16'h0000; // [R17]
					else
						word_out <= {4'h0, raw_in[9:0], 2'h0}; // [R17] [R19]
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- adc_serial_control_fifo.v
// serial command port, conversion sequencer and result fifo of the converter
// assumes serial pins are asynchronous to clock_in and much slower (10MHz max)
`default_nettype none
`include "adc_ctrl_consts.vh"

module adc_serial_control_fifo #(
	parameter DEPTH = `FIFO_DEPTH
)(
	// clock and reset
	input  wire        clock_in,
	input  wire        rst_in,
	input  wire        enable_in,
	// serial port
	input  wire        sclk_in,
	input  wire        cs_n_in,
	input  wire        sdi_in,
	output reg         sdo_out,
	output wire        sdo_oe_out,
	// conversion pins
	input  wire        convert_start_n_in,
	output reg         eoc_n_out,
	// analog model
	input  wire [10:0] raw_in,
	input  wire [11:0] temp_code_in,
	output wire [3:0]  channel_out,
	// status
	output wire        clock_mode_hi_out,
	output wire        clock_mode_lo_out,
	output wire [15:0] pair_diff_out,
	output wire [15:0] pair_bipolar_out
);

	// -------------------------------------------------------------------------
	// synchronisers and edges
	// -------------------------------------------------------------------------
	reg [1:0] sclk_s_q;
	reg [1:0] cs_s_q;
	reg [1:0] sdi_s_q;
	reg [1:0] cnv_s_q;
	reg       sclk_d_q;
	reg       cs_d_q;
	reg       cnv_d_q;

	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sclk_s_q <= 2'h0;
			cs_s_q   <= 2'h3;
			sdi_s_q  <= 2'h0;
			cnv_s_q  <= 2'h3;
			sclk_d_q <= 1'b0;
			cs_d_q   <= 1'b1;
			cnv_d_q  <= 1'b1;
		end
		else if (enable_in)
		begin
			sclk_s_q <= {sclk_s_q[0], sclk_in};
			cs_s_q   <= {cs_s_q[0], cs_n_in};
			sdi_s_q  <= {sdi_s_q[0], sdi_in};
			cnv_s_q  <= {cnv_s_q[0], convert_start_n_in};
			sclk_d_q <= sclk_s_q[1];
			cs_d_q   <= cs_s_q[1];
			cnv_d_q  <= cnv_s_q[1];
		end
	end

	wire cs_low   = !cs_s_q[1];
	wire cs_fall  = cs_d_q && !cs_s_q[1];
	wire sclk_up  = cs_low && !sclk_d_q && sclk_s_q[1];
	wire sclk_dn  = cs_low && sclk_d_q && !sclk_s_q[1];
	wire cnv_fall = cnv_d_q && !cnv_s_q[1];

	// -------------------------------------------------------------------------
	// command reception
	// -------------------------------------------------------------------------
	reg [7:0]  shift_q;
	reg [2:0]  bit_q;
	reg [1:0]  pend_q;      // 0 none, 1 unipolar byte, 2 bipolar byte
	reg [1:0]  mode_q;
	reg [3:0]  chan_q;
	reg [1:0]  scan_q;
	reg        temp_q;
	reg [7:0]  uni_q;
	reg [7:0]  bip_q;
	reg        byte_ev_q;
	reg [7:0]  byte_q;

	// one bit per channel pair, duplicated to both channels of the pair
	function [15:0] spread;
		input [7:0] p;
		integer k;
		begin
			spread = 16'h0000;
			for (k = 0; k < 8; k = k + 1)
			begin
				spread[2 * k]     = p[7 - k];
				spread[2 * k + 1] = p[7 - k];
			end
		end
	endfunction

	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			shift_q   <= 8'h00;
			bit_q     <= 3'h0;
			byte_ev_q <= 1'b0;
			byte_q    <= 8'h00;
		end
		else if (enable_in)
		begin
			byte_ev_q <= 1'b0;
			if (cs_fall)
				bit_q <= 3'h0; // [R6]
			else if (sclk_up)
			begin
				shift_q <= {shift_q[6:0], sdi_s_q[1]}; // [R2] [R5]
				bit_q   <= bit_q + 3'h1;
				if (bit_q == 3'h7)
				begin
					byte_ev_q <= 1'b1;
					byte_q    <= {shift_q[6:0], sdi_s_q[1]};
				end
			end
		end
	end

	wire is_conv  = byte_ev_q && pend_q == 2'h0 && byte_q[`CMD_CONV_BIT]; // [R24]
	wire is_setup = byte_ev_q && pend_q == 2'h0 && byte_q[7:6] == 2'h1;
	wire is_reset = byte_ev_q && pend_q == 2'h0 && byte_q[7:4] == 4'h1;

	// -------------------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_WAIT = 2'h2;

	reg [1:0]  st_q;
	reg [3:0]  cur_q;
	reg        do_temp_q;
	reg        start_q;
	reg        armed_q;
	wire       done;
	wire [15:0] word;
	wire [15:0] diffs = spread(uni_q | bip_q);
	wire [15:0] bips  = spread(bip_q);
	wire        last  = (scan_q == 2'h0) ? (cur_q >= chan_q) :
	                    (scan_q == 2'h1) ? (cur_q >= 4'he) : 1'b1;

	// [R11] externally timed: each rising serial edge while select is low counts one step
	sample_unit u_sample (
		.clock_in     (clock_in),
		.rst_in       (rst_in),
		.enable_in    (enable_in),
		.start_in     (start_q),
		.ext_tick_in  (sclk_up),
		.use_ext_in   (mode_q == 2'h3),
		.temp_in      (do_temp_q),
		.diff_in      (diffs[cur_q]),
		.bipolar_in   (bips[cur_q]),
		.raw_in       (raw_in),
		.temp_code_in (temp_code_in),
		.done_out     (done),
		.word_out     (word)
	);

	// fifo storage
	reg [15:0] mem_q [0:DEPTH-1];
	reg [3:0]  wr_q;
	reg [3:0]  rd_q;
	reg [4:0]  cnt_q;
	reg [15:0] tslot_q;
	reg        tvalid_q;
	reg        half_q;
	reg [7:0]  out_q;
	reg [2:0]  obit_q;
	reg        rose_q;

	wire        push      = st_q == ST_CONV && done && !do_temp_q;
	wire        temp_wr   = st_q == ST_CONV && done && do_temp_q;
	wire [15:0] head      = mem_q[rd_q];
	wire [15:0] head_next = mem_q[rd_q + 4'h1];
	wire        has_data  = cnt_q != 5'h00;
	wire [7:0]  cur_byte  = tvalid_q ? (half_q ? tslot_q[7:0] : tslot_q[15:8]) :
	                        has_data ? (half_q ? head[7:0] : head[15:8]) : 8'h00;
	wire [7:0]  nxt_byte  = tvalid_q ? (half_q ? (has_data ? head[15:8] : 8'h00) : tslot_q[7:0]) :
	                        has_data ? (half_q ? ((cnt_q > 5'h01) ? head_next[15:8] : 8'h00) : head[7:0]) :
	                        8'h00;
	wire        byte_done = sclk_up && !cs_fall && bit_q == 3'h7;
	wire        pop       = byte_done && !tvalid_q && has_data && half_q;

	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pend_q    <= 2'h0;
			mode_q    <= `CLOCK_MODE_RESET; // [R10]
			chan_q    <= 4'h0;
			scan_q    <= 2'h3;
			temp_q    <= 1'b0;
			uni_q     <= 8'h00;
			bip_q     <= 8'h00;
			st_q      <= ST_IDLE;
			cur_q     <= 4'h0;
			do_temp_q <= 1'b0;
			start_q   <= 1'b0;
			armed_q   <= 1'b0;
			eoc_n_out <= 1'b1;
			wr_q      <= 4'h0;
			rd_q      <= 4'h0;
			cnt_q     <= 5'h00;
			tslot_q   <= 16'h0000;
			tvalid_q  <= 1'b0;
			half_q    <= 1'b0;
			out_q     <= 8'h00;
			obit_q    <= 3'h0;
			rose_q    <= 1'b0;
			sdo_out   <= 1'b0;
		end
		else if (enable_in)
		begin
			start_q <= 1'b0;
			// register writes
			if (byte_ev_q && pend_q != 2'h0)
			begin
				if (pend_q == 2'h1)
					uni_q <= byte_q; // [R16]
				else
					bip_q <= byte_q; // [R16]
				pend_q <= 2'h0;
			end
			else if (is_setup)
			begin
				mode_q <= {byte_q[`SETUP_CK_HI], byte_q[`SETUP_CK_LO]}; // [R7]
				if (byte_q[`SETUP_DIFF_HI:`SETUP_DIFF_LO] == 2'h2)
					pend_q <= 2'h1; // [R5] [R16]
				else if (byte_q[`SETUP_DIFF_HI:`SETUP_DIFF_LO] == 2'h3)
					pend_q <= 2'h2;
			end
			else if (is_reset)
				tvalid_q <= 1'b0;
			else if (is_conv)
			begin
				chan_q <= byte_q[6:3];
				// scanning disabled when serially clocked [R11]
				scan_q <= (mode_q == 2'h3) ? 2'h3 : byte_q[2:1];
				temp_q <= byte_q[0];
				armed_q <= 1'b1;
			end

			// launch
			if (st_q == ST_IDLE)
			begin
				if ((is_conv && (mode_q == 2'h2 || mode_q == 2'h3)) || // [R10]
				    (cnv_fall && armed_q && !mode_q[1]))                 // [R8] [R9]
				begin
					st_q      <= ST_CONV;
					start_q   <= 1'b1;
					do_temp_q <= is_conv ? byte_q[0] : temp_q;
					cur_q     <= is_conv ? ((byte_q[2:1] == 2'h0) ? 4'h0 : byte_q[6:3])
					                     : ((scan_q == 2'h0) ? 4'h0 : chan_q);
				end
			end
			else if (st_q == ST_CONV && done)
			begin
				if (do_temp_q)
				begin
					tslot_q   <= word; // [R21]
					do_temp_q <= 1'b0;
					start_q   <= 1'b1;
				end
				else
				begin
					mem_q[wr_q] <= word; // [R18]
					if (mode_q == 2'h1)
					begin
						st_q <= last ? ST_IDLE : ST_WAIT; // [R9] one channel per start pulse
						eoc_n_out <= 1'b0; // [R13]
						cur_q <= last ? ((scan_q == 2'h0) ? 4'h0 : chan_q) : cur_q + 4'h1;
					end
					else if (last)
					begin
						st_q <= ST_IDLE;
						eoc_n_out <= (mode_q == 2'h3); // [R12] [R14]
					end
					else
					begin
						cur_q   <= cur_q + 4'h1;
						start_q <= 1'b1;
					end
				end
			end
			else if (st_q == ST_WAIT && cnv_fall)
			begin
				st_q    <= ST_CONV;
				start_q <= 1'b1;
			end
			if (cs_fall || cnv_fall || mode_q == 2'h3)
				eoc_n_out <= 1'b1; // [R14]

			// readout: a byte is peeked at select fall and consumed after its eighth rising edge,
			// so a trailing falling edge or a fresh select never loses data
			if (cs_fall)
			begin
				out_q   <= cur_byte; // [R20]
				sdo_out <= cur_byte[7]; // [R20]
				obit_q  <= 3'h6;
				rose_q  <= 1'b0;
			end
			else
			begin
				if (sclk_up)
					rose_q <= 1'b1;
				if (byte_done)
				begin
					out_q <= nxt_byte; // [R19] [R21]
					if (tvalid_q || has_data)
						half_q <= !half_q;
					if (tvalid_q && half_q)
						tvalid_q <= 1'b0;
				end
				// mode 3 opens with a falling edge before any rising one; it must not shift
				if (sclk_dn && rose_q)
				begin
					sdo_out <= out_q[obit_q]; // [R3]
					obit_q  <= obit_q - 3'h1;
				end
			end
			// fifo pointers: a push and a pop may meet in one cycle
			if (is_reset)
			begin
				cnt_q  <= 5'h00;
				rd_q   <= wr_q;
				half_q <= 1'b0;
			end
			else if (push)
			begin
				wr_q <= wr_q + 4'h1;
				if (pop || cnt_q == DEPTH)
					rd_q <= rd_q + 4'h1; // [R18] oldest dropped when full
				if (!pop && cnt_q != DEPTH)
					cnt_q <= cnt_q + 5'h01;
			end
			else if (pop)
			begin
				rd_q  <= rd_q + 4'h1;
				cnt_q <= cnt_q - 5'h01;
			end
			// a new temperature result wins over a read in the same cycle
			if (temp_wr)
			begin
				tvalid_q <= 1'b1; // [R21]
				half_q   <= 1'b0;
			end
		end
	end

	assign sdo_oe_out        = cs_low; // [R23]
	assign channel_out       = cur_q;
	assign clock_mode_hi_out = mode_q[1];
	assign clock_mode_lo_out = mode_q[0];
	assign pair_diff_out     = diffs;
	assign pair_bipolar_out  = bips;

endmodule
`default_nettype wire

//--- adc_ctrl_sva.sv
// port assertions for the converter control block
// assumes bind onto the block; pins are async and synchronised inside
`default_nettype none
module adc_ctrl_sva #(
	parameter int DEPTH = 16
)(
	// clock and reset
	input wire logic        clock_in,
	input wire logic        rst_in,
	// pins
	input wire logic        sclk_in,
	input wire logic        cs_n_in,
	input wire logic        convert_start_n_in,
	input wire logic        sdo_out,
	input wire logic        sdo_oe_out,
	input wire logic        eoc_n_out,
	// status
	input wire logic        clock_mode_hi_out,
	input wire logic        clock_mode_lo_out,
	input wire logic [15:0] pair_diff_out,
	input wire logic [15:0] pair_bipolar_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// helpers
	// ----
	logic       sclk_q;
	logic       cs_q;
	logic [3:0] edge_q;
	logic [3:0] pin_q;
	// counters saturate so long idle spans never wrap into a false match
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
			edge_q <= 4'hf;
			pin_q  <= 4'hf;
		end
		else
		begin
			sclk_q <= sclk_in;
			cs_q   <= cs_n_in;
			edge_q <= ((sclk_q && !sclk_in) || cs_q != cs_n_in) ? 4'h0 : edge_q + {3'h0, edge_q != 4'hf};
			pin_q  <= (!cs_n_in || !convert_start_n_in) ? 4'h0 : pin_q + {3'h0, pin_q != 4'hf};
		end
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	sequence s_sel_fall;
		$fell(cs_n_in);
	endsequence
	sequence s_pins_idle;
		cs_n_in && convert_start_n_in;
	endsequence
	property p_oe_off;
		cs_n_in [*4] |-> !sdo_oe_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("data output driven while deselected");
	property p_eoc_clr;
		s_sel_fall |-> ##5 eoc_n_out;
	endproperty
	a_eoc_clr: assert property (p_eoc_clr) else $error("end flag not cleared by select");
	property p_eoc_m11;
		clock_mode_hi_out && clock_mode_lo_out |-> eoc_n_out;
	endproperty
	a_eoc_m11: assert property (p_eoc_m11) else $error("end flag low in serial clocked mode");
	property p_eoc_rise;
		$rose(eoc_n_out) |-> pin_q < 4'h6;
	endproperty
	a_eoc_rise: assert property (p_eoc_rise) else $error("end flag rose without a pin fall");
	property p_eoc_fall;
		$fell(eoc_n_out) |-> s_pins_idle;
	endproperty
	a_eoc_fall: assert property (p_eoc_fall) else $error("end flag fell during a request");
	property p_mode_sel;
		!$stable({clock_mode_hi_out, clock_mode_lo_out}) |-> !cs_n_in;
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("mode changed outside a frame");
	property p_pair_sel;
		!$stable({pair_diff_out, pair_bipolar_out}) |-> !cs_n_in;
	endproperty
	a_pair_sel: assert property (p_pair_sel) else $error("pairing changed outside a frame");
	property p_sdo_edge;
		$changed(sdo_out) && sdo_oe_out |-> edge_q < 4'h7;
	endproperty
	a_sdo_edge: assert property (p_sdo_edge) else $error("data output moved off a falling edge");
endmodule
bind adc_serial_control_fifo adc_ctrl_sva #(.DEPTH(DEPTH)) u_sva (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.sclk_in(sclk_in),
	.cs_n_in(cs_n_in),
	.convert_start_n_in(convert_start_n_in),
	.sdo_out(sdo_out),
	.sdo_oe_out(sdo_oe_out),
	.eoc_n_out(eoc_n_out),
	.clock_mode_hi_out(clock_mode_hi_out),
	.clock_mode_lo_out(clock_mode_lo_out),
	.pair_diff_out(pair_diff_out),
	.pair_bipolar_out(pair_bipolar_out)
);
`default_nettype wire

//--- spi_host_model.sv
// serial master and start pin model for the converter control block
// assumes the bench clock paces every pin change; one sclk is 16 clocks
`default_nettype none
module spi_host_model (
	// clock
	input  wire logic clock_in,
	// pins
	output var logic  sclk_out,
	output var logic  cs_n_out,
	output var logic  sdi_out,
	output var logic  convert_start_n_out,
	input  wire logic sdo_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sclk_out            = 1'b0;
		cs_n_out            = 1'b1;
		sdi_out             = 1'b0;
		convert_start_n_out = 1'b1;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// sclk stands still at pol between frames; pol 1 gives mode 3
	task automatic xfer(input logic [15:0] tx, input int nb, input logic pol, output logic [15:0] rx);
		rx = 16'h0;
		hc(1);
		sclk_out <= pol;
		hc(8);
		cs_n_out <= 1'b0;
		hc(8);
		for (int i = 0; i < nb; i++)
		begin
			sclk_out <= 1'b0;
			sdi_out  <= tx[15 - i];
			hc(8);
			sclk_out <= 1'b1;
			rx[15 - i] = sdo_in;
			hc(8);
		end
		sclk_out <= pol;
		hc(8);
		cs_n_out <= 1'b1;
		sdi_out  <= ~sdi_out;
		hc(8);
	endtask
	task automatic pulse_start();
		hc(1);
		convert_start_n_out <= 1'b0;
		hc(8);
		convert_start_n_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- adc_serial_control_fifo_tb.sv
// self-checking bench for the converter control block
// assumes the host model owns every serial and start pin
`default_nettype none
module adc_serial_control_fifo_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clock_in;
	logic             rst_in;
	logic             enable_in;
	logic [10:0]      raw_in;
	logic [11:0]      temp_code_in;
	logic             sdo_last;
	logic [15:0]      rx;
	int               failures;
	int               n_checks;
	int               cycles;
	wire logic        sclk;
	wire logic        cs_n;
	wire logic        sdi;
	wire logic        conv_n;
	wire logic        sdo;
	wire logic        sdo_oe;
	wire logic        sdo_w;
	wire logic        eoc_n;
	wire logic        mode_hi;
	wire logic        mode_lo;
	wire logic [15:0] pair_diff;
	wire logic [15:0] pair_bip;
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// a released line shows the inverse of its last driven level
	always @(posedge clock_in)
		if (sdo_oe)
			sdo_last <= sdo;
	assign sdo_w = sdo_oe ? sdo : ~sdo_last;
	adc_serial_control_fifo #(.DEPTH(16)) u_dut (
		.clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
		.convert_start_n_in(conv_n), .eoc_n_out(eoc_n), .raw_in(raw_in), .temp_code_in(temp_code_in),
		.channel_out(), .clock_mode_hi_out(mode_hi), .clock_mode_lo_out(mode_lo),
		.pair_diff_out(pair_diff), .pair_bipolar_out(pair_bip));
	spi_host_model u_host (
		.clock_in(clock_in), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
		.convert_start_n_out(conv_n), .sdo_in(sdo_w));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_eoc();
		for (int n = 0; n < 3000 && eoc_n !== 1'b0; n++)
			@(posedge clock_in);
		chk({15'h0, eoc_n}, 16'h0000);
	endtask
	task automatic cmd(input logic [7:0] b, input logic pol);
		u_host.xfer({b, 8'h00}, 8, pol, rx);
	endtask
	task automatic rd(input logic [15:0] mask, input logic [15:0] exp);
		u_host.xfer(16'h0000, 16, 1'b0, rx);
		chk(rx & mask, exp);
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++)
		begin
			cmd(8'h40 | 8'(m << 4), m[0]);
			chk({14'h0, mode_hi, mode_lo}, 16'(m));
		end
		chk({15'h0, eoc_n}, 16'h0001);
		cmd(8'h60, 1'b0);
		$display("test modes done");
	endtask
	task automatic t_single();
		raw_in <= 11'h155;
		cmd(8'h86, 1'b0);
		wait_eoc();
		rd(16'hfffc, 16'h0554);
		chk({15'h0, eoc_n}, 16'h0001);
		rd(16'hffff, 16'h0000);
		$display("test single done");
	endtask
	task automatic t_start(input logic [7:0] setup, input logic [9:0] val);
		raw_in <= {1'b0, val};
		cmd(setup, 1'b0);
		cmd(8'h86, 1'b0);
		repeat (600) @(posedge clock_in);
		chk({15'h0, eoc_n}, 16'h0001);
		u_host.pulse_start();
		wait_eoc();
		rd(16'hfffc, {4'h0, val, 2'b00});
		$display("test start pin done");
	endtask
	task automatic t_fifo();
		// filled by start pulses so that no command frame reads the fifo meanwhile
		cmd(8'h40, 1'b0);
		cmd(8'h86, 1'b0);
		for (int i = 0; i < 17; i++)
		begin
			raw_in <= 11'(i + 1);
			u_host.pulse_start();
			wait_eoc();
		end
		for (int i = 0; i < 16; i++)
			rd(16'hfffc, 16'((i + 2) << 2));
		rd(16'hffff, 16'h0000);
		cmd(8'h60, 1'b0);
		$display("test fifo done");
	endtask
	task automatic t_temp();
		raw_in       <= 11'h0aa;
		temp_code_in <= 12'h123;
		cmd(8'h87, 1'b0);
		wait_eoc();
		temp_code_in <= 12'hf38;
		cmd(8'h87, 1'b0);
		wait_eoc();
		rd(16'hffff, 16'h0f38);
		rd(16'hfffc, 16'h02a8);
		rd(16'hfffc, 16'h02a8);
		$display("test temp done");
	endtask
	task automatic t_pair();
		u_host.xfer(16'h6280, 16, 1'b0, rx);
		chk({15'h0, pair_diff[0]}, 16'h0001);
		raw_in <= 11'h7f0;
		cmd(8'h86, 1'b0);
		wait_eoc();
		rd(16'hfffc, 16'h0000);
		u_host.xfer(16'h6380, 16, 1'b0, rx);
		chk({15'h0, pair_bip[0]}, 16'h0001);
		$display("test pairing done");
	endtask
	// cut a hang short well above the roughly 21k cycles the tests need
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			final_report();
		end
	end
	initial
	begin
		rst_in       = 1'b1;
		enable_in    = 1'b1;
		raw_in       = 11'h0;
		temp_code_in = 12'h0;
		sdo_last     = 1'b0;
		failures     = 0;
		n_checks     = 0;
		cycles       = 0;
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk({12'h0, eoc_n, sdo_oe, mode_hi, mode_lo}, 16'h000a);
		$display("test reset done");
		t_modes();
		t_single();
		t_start(8'h40, 10'h2aa);
		t_start(8'h50, 10'h0f3);
		cmd(8'h60, 1'b0);
		t_fifo();
		t_temp();
		t_pair();
		final_report();
	end
endmodule
`default_nettype wire
